// [pbes_defs.vh]
// register map, field layout and reset values of the port b edge select block
`ifndef PBES_DEFS_VH
`define PBES_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PBES_OFF_EDGE_POL 4'h0
`define PBES_OFF_PIN_EN 4'h4
`define PBES_OFF_PULL_EN 4'h8
`define PBES_OFF_STATUS 4'hC
`define PBES_OFF_MASK 5'h10
`define PBES_OFF_PIN_STATE 5'h14
// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define PBES_NPIN 4
`define PBES_FIELD_MSB 3
`define PBES_RST_EDGE_POL 4'h0
`define PBES_RST_PIN_EN 4'h0
`define PBES_RST_PULL_EN 4'h0
`define PBES_RST_STATUS 4'h0
`define PBES_RST_MASK 4'h0
// ----------------------------------------
// axi response codes
// ----------------------------------------
`define PBES_RESP_OKAY 2'h0
`define PBES_RESP_SLVERR 2'h2
`endif

// [pbes_pin_det.v]
// per-pin polarity, pull selection and detection of the edge into the active level
`timescale 1ns/100ps
`include "pbes_defs.vh"
module pbes_pin_det (
  input wire i_clk,
  input wire i_nrst,
  input wire [3:0] i_pin,
  input wire [3:0] i_pol,
  input wire [3:0] i_en,
  input wire [3:0] i_pull_en,
  output wire [3:0] o_event,
  output wire [3:0] o_pull_up,
  output wire [3:0] o_pull_dn
);
  reg [3:0] prev_q;
  wire [3:0] act;
  genvar g;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_q <= 4'h0;
    end else begin
      prev_q <= act;
    end
  end
  generate
    for (g = 0; g < `PBES_NPIN; g = g + 1) begin : g_pin
      // one bit picks both polarity and pull kind
      // pol 0: low active, pol 1: high active
      assign act[g] = i_pol[g] ? i_pin[g] : ~i_pin[g];
      // edge into the active level; a polarity change into it also counts
      assign o_event[g] = i_en[g] & act[g] & ~prev_q[g];
      // pull only while pulling is enabled
      assign o_pull_up[g] = i_pull_en[g] & ~i_pol[g];
      assign o_pull_dn[g] = i_pull_en[g] & i_pol[g];
    end
  endgenerate
endmodule // pbes_pin_det

// [pbes_top.v]
// port b interrupt edge/polarity select with axi4-lite registers
// Overview of operation
// - one bit sets polarity and pull kind
// - bit 0: pull-up, falling/low detect
// - bit 1: pull-down, rising/high detect
// - pull applied only when pulling enabled
// - per-pin enable gates interrupt participation
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "pbes_defs.vh"
module pbes_top (
  input wire I_CORE_CLK,
  input wire I_NRST,
  input wire [3:0] I_PIN,
  input wire I_AWVALID,
  output reg O_AWREADY,
  input wire [31:0] I_AWADDR,
  input wire I_WVALID,
  output reg O_WREADY,
  input wire [31:0] I_WDATA,
  input wire [3:0] I_WSTRB,
  output reg O_BVALID,
  input wire I_BREADY,
  output reg [1:0] O_BRESP,
  input wire I_ARVALID,
  output reg O_ARREADY,
  input wire [31:0] I_ARADDR,
  output reg O_RVALID,
  input wire I_RREADY,
  output reg [31:0] O_RDATA,
  output reg [1:0] O_RRESP,
  output reg [3:0] O_PULL_UP,
  output reg [3:0] O_PULL_DN,
  output reg O_IRQ
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  // control words hold four bits each; bits above read as zero
  reg [3:0] pol_q;
  reg [3:0] pin_en_q;
  reg [3:0] pull_en_q;
  reg [3:0] status_q;
  reg [3:0] mask_q;
  reg aw_got_q;
  reg w_got_q;
  reg [31:0] awaddr_q;
  reg [31:0] wdata_q;
  reg wstrb0_q;
  wire [3:0] evt;
  wire [3:0] pu;
  wire [3:0] pd;
  wire do_wr;
  wire [3:0] clr;
  reg [31:0] rdata_d;
  reg rhit_d;
  reg whit;
  wire [3:0] status_d;
  wire irq_d;
  wire wr_ok;
  genvar g;

  // ----------------------------------------
  // pin detection
  // ----------------------------------------
  // edge into the active level only: a level still held after a clear
  // sets nothing more, so software sees one event per edge
  pbes_pin_det pbes_pin_det_inst (
    .i_clk(I_CORE_CLK),
    .i_nrst(I_NRST),
    .i_pin(I_PIN),
    .i_pol(pol_q),
    .i_en(pin_en_q),
    .i_pull_en(pull_en_q),
    .o_event(evt),
    .o_pull_up(pu),
    .o_pull_dn(pd)
  );

  // ----------------------------------------
  // write channel: address and data in either order
  // ----------------------------------------
  // unmapped words answer slverr and change nothing; the pin state word
  // answers okay but is read only
  assign do_wr = aw_got_q & w_got_q & ~O_BVALID;

  always @* begin
    case (awaddr_q[4:0])
      {1'b0, `PBES_OFF_EDGE_POL}: whit = 1'b1;
      {1'b0, `PBES_OFF_PIN_EN}: whit = 1'b1;
      {1'b0, `PBES_OFF_PULL_EN}: whit = 1'b1;
      {1'b0, `PBES_OFF_STATUS}: whit = 1'b1;
      `PBES_OFF_MASK: whit = 1'b1;
      `PBES_OFF_PIN_STATE: whit = 1'b1;
      default: whit = 1'b0;
    endcase
    if (awaddr_q[31:5] != 27'h0) begin
      whit = 1'b0;
    end
  end

  // a write lands only with the low byte lane, the one that holds bits 3:0
  assign wr_ok = do_wr & wstrb0_q & (awaddr_q[31:5] == 27'h0);
  assign clr = (wr_ok && awaddr_q[4:0] == {1'b0, `PBES_OFF_STATUS}) ? wdata_q[3:0] : 4'h0;

  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_AWREADY <= 1'b1;
      O_WREADY <= 1'b1;
      O_BVALID <= 1'b0;
      O_BRESP <= `PBES_RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb0_q <= 1'b0;
      pol_q <= `PBES_RST_EDGE_POL;
      pin_en_q <= `PBES_RST_PIN_EN;
      pull_en_q <= `PBES_RST_PULL_EN;
      mask_q <= `PBES_RST_MASK;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        awaddr_q <= I_AWADDR;
        aw_got_q <= 1'b1;
        O_AWREADY <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        wdata_q <= I_WDATA;
        wstrb0_q <= I_WSTRB[0];
        w_got_q <= 1'b1;
        O_WREADY <= 1'b0;
      end
      if (do_wr) begin
        O_BVALID <= 1'b1;
        O_BRESP <= whit ? `PBES_RESP_OKAY : `PBES_RESP_SLVERR;
        // only the low byte lane carries implemented bits
        if (wr_ok) begin
          case (awaddr_q[4:0])
            {1'b0, `PBES_OFF_EDGE_POL}: pol_q <= wdata_q[3:0];
            {1'b0, `PBES_OFF_PIN_EN}: pin_en_q <= wdata_q[3:0];
            {1'b0, `PBES_OFF_PULL_EN}: pull_en_q <= wdata_q[3:0];
            `PBES_OFF_MASK: mask_q <= wdata_q[3:0];
            default: ;
          endcase
        end
      end
      if (O_BVALID && I_BREADY) begin
        O_BVALID <= 1'b0;
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        O_AWREADY <= 1'b1;
        O_WREADY <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // read channel
  // ----------------------------------------
  // pin state reads the raw pins, ahead of any polarity
  always @* begin
    rdata_d = 32'h0;
    rhit_d = (I_ARADDR[31:5] == 27'h0);
    case (I_ARADDR[4:0])
      {1'b0, `PBES_OFF_EDGE_POL}: rdata_d = {28'h0, pol_q};
      {1'b0, `PBES_OFF_PIN_EN}: rdata_d = {28'h0, pin_en_q};
      {1'b0, `PBES_OFF_PULL_EN}: rdata_d = {28'h0, pull_en_q};
      {1'b0, `PBES_OFF_STATUS}: rdata_d = {28'h0, status_q};
      `PBES_OFF_MASK: rdata_d = {28'h0, mask_q};
      `PBES_OFF_PIN_STATE: rdata_d = {28'h0, I_PIN};
      default: rhit_d = 1'b0;
    endcase
    if (!rhit_d) begin
      rdata_d = 32'h0;
    end
  end

  // data is captured as the address is taken, so it stands until rready
  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_ARREADY <= 1'b1;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0;
      O_RRESP <= `PBES_RESP_OKAY;
    end else begin
      if (I_ARVALID && O_ARREADY) begin
        O_ARREADY <= 1'b0;
        O_RVALID <= 1'b1;
        O_RDATA <= rdata_d;
        O_RRESP <= rhit_d ? `PBES_RESP_OKAY : `PBES_RESP_SLVERR;
      end else if (O_RVALID && I_RREADY) begin
        O_RVALID <= 1'b0;
        O_ARREADY <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // status, interrupt and pull outputs
  // ----------------------------------------
  // one sticky cell per pin; set wins over a same-cycle write-one clear
  generate
    for (g = 0; g < `PBES_NPIN; g = g + 1) begin : g_sts
      assign status_d[g] = evt[g] | (status_q[g] & ~clr[g]);
    end
  endgenerate
  // irq follows the next status, so it rises on the same edge as the bit
  assign irq_d = |(status_d & mask_q);

  always @(posedge I_CORE_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      status_q <= `PBES_RST_STATUS;
      O_IRQ <= 1'b0;
      O_PULL_UP <= 4'h0;
      O_PULL_DN <= 4'h0;
    end else begin
      status_q <= status_d;
      O_IRQ <= irq_d;
      O_PULL_UP <= pu;
      O_PULL_DN <= pd;
    end
  end
endmodule // pbes_top

// [pbes_chk.sv]
// assertion checker for the port b edge select block
`timescale 1ns/100ps
module pbes_chk (
  input wire I_CORE_CLK,
  input wire I_NRST,
  input wire O_AWREADY,
  input wire O_WREADY,
  input wire O_BVALID,
  input wire I_BREADY,
  input wire O_ARREADY,
  input wire O_RVALID,
  input wire I_RREADY,
  input wire [31:0] O_RDATA,
  input wire [3:0] O_PULL_UP,
  input wire [3:0] O_PULL_DN,
  input wire O_IRQ
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);
  sequence s_rel;
    !$past(I_NRST);
  endsequence
  property p_excl;
    (O_PULL_UP & O_PULL_DN) == 4'h0;
  endproperty
  a_excl: assert property (p_excl) else $error("both pulls on");
  property p_hi;
    O_RVALID |-> O_RDATA[31:4] == 28'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_rst;
    s_rel |-> (O_PULL_UP | O_PULL_DN) == 4'h0 && !O_IRQ;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  // pulls move only as a register write lands
  property p_pwr;
    $changed(O_PULL_UP | O_PULL_DN) |-> O_BVALID || $past(O_BVALID);
  endproperty
  a_pwr: assert property (p_pwr) else $error("pull moved alone");
  // write response and read data close a transfer and reopen the channel
  sequence s_b_take;
    O_BVALID && I_BREADY;
  endsequence
  sequence s_wr_idle;
    !O_BVALID && O_AWREADY && O_WREADY;
  endsequence
  sequence s_r_take;
    O_RVALID && I_RREADY;
  endsequence
  sequence s_rd_idle;
    !O_RVALID && O_ARREADY;
  endsequence
  property p_bdone;
    s_b_take |=> s_wr_idle;
  endproperty
  a_bdone: assert property (p_bdone) else $error("write channel not reopened");
  property p_rdone;
    s_r_take |=> s_rd_idle;
  endproperty
  a_rdone: assert property (p_rdone) else $error("read channel not reopened");
  property p_bbusy;
    O_BVALID |-> !O_AWREADY && !O_WREADY;
  endproperty
  a_bbusy: assert property (p_bbusy) else $error("write taken while busy");
endmodule // pbes_chk
bind pbes_top pbes_chk pbes_chk_inst (.*);

// [pbes_pin_drv.sv]
// partner model: pin drivers and pull levels on port b
`timescale 1ns/100ps
module pbes_pin_drv (
  input wire i_clk,
  input wire [3:0] i_en,
  input wire [3:0] i_val,
  input wire [3:0] i_pu,
  input wire [3:0] i_pd,
  output logic [3:0] o_pin
);
  logic [3:0] flt_q = 4'h5;
  // a floating line wanders, never trust it
  always @(posedge i_clk) flt_q <= ~flt_q;
  always_comb o_pin = (i_en & i_val) | (~i_en & (i_pu | (~i_pd & flt_q)));
endmodule // pbes_pin_drv

// [tb_port_b_interrupt_edge_select.sv]
// self-checking bench for the port b edge select block
`timescale 1ns/100ps
module tb_port_b_interrupt_edge_select;
  logic clk = 0, nrst = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic awr, wrr, bv, arr, rv, irq;
  logic [31:0] aw = 0, wd = 0, ara = 0, rdat;
  logic [3:0] den = 0, dval = 0, pin, pu, pd;
  logic [1:0] rr, br;
  logic [3:0] ws = 4'hF;
  int errors = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  pbes_pin_drv pbes_pin_drv_inst (.i_clk(clk), .i_en(den), .i_val(dval), .i_pu(pu),
    .i_pd(pd), .o_pin(pin));
  pbes_top pbes_top_inst (.I_CORE_CLK(clk), .I_NRST(nrst), .I_PIN(pin),
    .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(aw), .I_WVALID(wv), .O_WREADY(wrr),
    .I_WDATA(wd), .I_WSTRB(ws), .O_BVALID(bv), .I_BREADY(bre), .O_BRESP(br),
    .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rre),
    .O_RDATA(rdat), .O_RRESP(rr), .O_PULL_UP(pu), .O_PULL_DN(pd), .O_IRQ(irq));
  task chk(input string nm, input [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task wr_r(input [31:0] a, d, input [1:0] er);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge clk) {awv, wv, aw, wd, bre} <= {2'b11, a, d, 1'b1};
    while (!(ta && tw)) begin
      @(posedge clk);
      ta |= awr;
      tw |= wrr;
      awv <= !ta;
      wv <= !tw;
    end
    do @(posedge clk); while (!bv);
    bre <= 0;
    chk("bresp", br, er);
  endtask
  task wr(input [31:0] a, d);
    wr_r(a, d, 2'h0);
  endtask
  task rd(input [31:0] a, exp, input [1:0] er);
    @(posedge clk) {arv, ara, rre} <= {1'b1, a, 1'b1};
    do @(posedge clk); while (!arr);
    arv <= 0;
    do @(posedge clk); while (!rv);
    rre <= 0;
    chk("rdata", rdat, exp);
    chk("rresp", rr, er);
  endtask
  task pins(input [3:0] v);
    @(posedge clk) {den, dval} <= {4'hF, v};
    repeat (4) @(posedge clk);
  endtask
  task t_regs;
    rd(0, 0, 0);
    rd(32'h18, 0, 2'h2);
    wr(0, 32'hFF);
    rd(0, 32'hF, 0);
    $display("regs done");
  endtask
  task t_pull;
    wr(8, 32'hF);
    wr(0, 3);
    repeat (3) @(posedge clk);
    chk("pull_up", pu, 4'hC);
    chk("pull_dn", pd, 4'h3);
    rd(32'h14, 32'hC, 0);
    wr(8, 0);
    repeat (3) @(posedge clk);
    chk("pull_off", pu | pd, 0);
    $display("pull done");
  endtask
  task t_irq;
    pins(4'hD);
    wr(0, 2);
    wr(16, 32'hF);
    wr(4, 3);
    pins(4'hC);
    rd(12, 1, 0);
    chk("irq", irq, 1);
    wr(12, 32'hF);
    repeat (2) @(posedge clk);
    chk("irq_clr", irq, 0);
    pins(4'hE);
    rd(12, 2, 0);
    wr(12, 32'hF);
    pins(4'h3);
    rd(12, 0, 0);
    $display("irq done");
  endtask
  task t_bus;
    wr_r(32'h18, 32'hF, 2'h2);
    ws <= 4'hE;
    wr(0, 32'h5);
    ws <= 4'hF;
    rd(0, 32'h2, 0);
    wr(16, 32'hE);
    pins(4'h2);
    rd(12, 1, 0);
    chk("irq_masked", irq, 0);
    wr(16, 32'hF);
    repeat (2) @(posedge clk);
    chk("irq_unmask", irq, 1);
    wr(12, 32'hF);
    $display("bus done");
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1;
    t_regs;
    t_pull;
    t_irq;
    t_bus;
    tally_and_finish;
  end
  initial begin
    #50000;
    errors++;
    tally_and_finish;
  end
endmodule // tb_port_b_interrupt_edge_select
